/* File: daalc_map.svh */
// Purpose: address map, reset values and timing counts of the line
//          control and status register bank
// Assumes: 32-bit AXI4-Lite data, one aligned word per register
// Notes:   register indices are kept and scaled by four into byte addresses
`ifndef DAALC_MAP_SVH
`define DAALC_MAP_SVH

// register indices as printed, and the bank's own event register
`define DAALC_IDX_TRIM   8'h19
`define DAALC_IDX_DC     8'h1a
`define DAALC_IDX_RSVD   8'h1b
`define DAALC_IDX_LOOP   8'h1c
`define DAALC_IDX_VOLT   8'h1d
`define DAALC_IDX_EVT    8'h20

// byte addresses on the 12-bit bus address
`define DAALC_ADDR_TRIM  {2'b00, `DAALC_IDX_TRIM, 2'b00}
`define DAALC_ADDR_DC    {2'b00, `DAALC_IDX_DC, 2'b00}
`define DAALC_ADDR_RSVD  {2'b00, `DAALC_IDX_RSVD, 2'b00}
`define DAALC_ADDR_LOOP  {2'b00, `DAALC_IDX_LOOP, 2'b00}
`define DAALC_ADDR_VOLT  {2'b00, `DAALC_IDX_VOLT, 2'b00}
`define DAALC_ADDR_EVT   {2'b00, `DAALC_IDX_EVT, 2'b00}

// field positions
`define DAALC_BIT_BUSY    7
`define DAALC_BIT_MANUAL  6
`define DAALC_BIT_POLEVT  0
`define DAALC_BIT_NOLINE  1
`define DAALC_BIT_LOWCUR  2

// reset values
`define DAALC_RST_TRIM   8'h00
`define DAALC_RST_DC     8'h00
`define DAALC_RST_MEAS   8'h00
`define DAALC_RST_EVT    3'h0

// bus answers
`define DAALC_RESP_OKAY   2'b00
`define DAALC_RESP_SLVERR 2'b10

// timing: calibration run length
`define DAALC_CLK_PERIOD_NS 10
`define DAALC_CAL_TIME_NS   2000
`define DAALC_CAL_CYCLES \
	((`DAALC_CAL_TIME_NS + `DAALC_CLK_PERIOD_NS - 1) / `DAALC_CLK_PERIOD_NS)

`endif

/* File: daalc_pkg.sv */
// Purpose: types shared by the line control register bank
// Assumes: nothing beyond SystemVerilog packed types
// Notes:   all state of each module is one packed struct from here, except the pol_flip_r flop of daalc_regs
`default_nettype none
package daalc_pkg;

	// calibration sequencer states
	typedef enum logic [0:0] {
		CAL_IDLE,
		CAL_BUSY
	} daalc_cal_e;

	// dc termination settings word
	typedef struct packed {
		logic [1:0] v_adj;
		logic [1:0] min_i;
		logic [1:0] rsvd;
		logic       cap;
		logic       imp;
	} daalc_dc_s;

	// measurement holder state
	typedef struct packed {
		logic [7:0] value;
		logic       seen;
		logic       flip;
		logic       zero;
	} daalc_meas_s;

	// register bank state
	typedef struct packed {
		daalc_cal_e  cal;
		logic [7:0]  cal_cnt;
		logic        first;
		logic        manual;
		logic        disable_auto;
		logic        spare;
		logic [3:0]  trim;
		daalc_dc_s   dc;
		logic [2:0]  evt;
		logic        aw_held;
		logic [11:0] aw_addr;
		logic        w_held;
		logic [31:0] wdata;
		logic        wstrb0;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
	} daalc_state_s;

endpackage
`default_nettype wire

/* File: daalc_meas_hold.sv */
// Purpose: hold one eight-bit line-side measurement and flag its events
// Assumes: sample strobe and value are synchronous to the clock
// Notes:   sign change is reported only after a first sample was taken
`default_nettype none
`include "daalc_map.svh"
module daalc_meas_hold (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// line side
	input  wire logic       sample,
	input  wire logic [7:0] value_in,
	// held reading and events
	output logic [7:0]      value,
	output logic            sign_flip,
	output logic            is_zero
);
	daalc_pkg::daalc_meas_s st_r;
	daalc_pkg::daalc_meas_s st_nxt;

	// capture on every strobe, whatever the hook state
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.flip = 1'b0;
		if (sample)
		begin
			st_nxt.value = value_in;
			st_nxt.seen = 1'b1;
			st_nxt.zero = (value_in == 8'h00);
			// first sample has nothing to compare against
			st_nxt.flip = st_r.seen && (value_in[7] != st_r.value[7]);
		end
	end

	// state register
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			st_r.value <= `DAALC_RST_MEAS;
			st_r.seen <= 1'b0;
			st_r.flip <= 1'b0;
			st_r.zero <= 1'b0;
		end
		else
			st_r <= st_nxt;
	end

	assign value = st_r.value;
	assign sign_flip = st_r.flip;
	assign is_zero = st_r.zero;
endmodule
`default_nettype wire

/* File: daalc_regs.sv */
// Purpose: line control and status register bank on an AXI4-Lite slave
// Assumes: one write and one read at most outstanding; single clock
// Notes:   the line-side analog part consumes the settings and feeds
//          the two measurements through a sample strobe
//
// Notes on behaviour
// - calibration busy reads at bit 7, high while calibration runs
// - writing 1 to manual bit starts a resistor calibration; here only when the bit held 0 and no calibration is running
// - bit 5 disables automatic calibration; resets to 0; here no effect: the only auto run starts right after reset, when it is 0
// - reserved bit 4 accepts 0 or 1 with no effect
// - voltage adjust field selects 3.1, 3.2, 3.35 or 3.5 V setpoint
// - minimum loop current field selects 10, 12, 14 or 16 mA
// - current cap bit limits loop current to 60 mA when set
// - impedance bit selects 50 ohm (0) or 800 ohm (1)
// - loop current reads as eight bits, 1.1 mA per step
// - loop current of zero means current too low to operate
// - line voltage reads as eight bits, 1 V per step
// - line voltage updates both on-hook and off-hook
// - voltage bit 7 is polarity; a change flags a reversal
// - line voltage is a signed two's complement value
// - line voltage of zero means no line connected
//
// Added by the designer: the AXI4-Lite register port.
`default_nettype none
`include "daalc_map.svh"
module daalc_regs (
	// clock and reset
	input  wire logic        CORE_CLK,
	input  wire logic        RSTN,
	// axi4-lite write address
	input  wire logic [11:0] S_AXI_AWADDR,
	input  wire logic        S_AXI_AWVALID,
	output logic             S_AXI_AWREADY,
	// axi4-lite write data
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	input  wire logic        S_AXI_WVALID,
	output logic             S_AXI_WREADY,
	// axi4-lite write response
	output logic [1:0]       S_AXI_BRESP,
	output logic             S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	// axi4-lite read address
	input  wire logic [11:0] S_AXI_ARADDR,
	input  wire logic        S_AXI_ARVALID,
	output logic             S_AXI_ARREADY,
	// axi4-lite read data
	output logic [31:0]      S_AXI_RDATA,
	output logic [1:0]       S_AXI_RRESP,
	output logic             S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY,
	// line-side dc termination settings
	output logic [1:0]       LINE_VOLTAGE_ADJUST,
	output logic [1:0]       MIN_LOOP_CURRENT_SELECT,
	output logic             CURRENT_CAP_ENABLE,
	output logic             DC_IMPEDANCE_SELECT,
	// line-side calibration
	output logic             CALIBRATION_RUN,
	output logic [3:0]       TRIM_VALUE,
	input  wire logic [3:0]  CAL_TRIM_IN,
	// line-side measurements
	input  wire logic        MEAS_STROBE,
	input  wire logic [7:0]  LOOP_CURRENT_IN,
	input  wire logic [7:0]  LINE_VOLTAGE_IN,
	output logic [7:0]       LOOP_CURRENT_VALUE,
	output logic [7:0]       LINE_VOLTAGE_VALUE,
	output logic             POLARITY_REVERSED
);
	localparam logic [7:0] CAL_LAST = 8'(`DAALC_CAL_CYCLES - 1);

	daalc_pkg::daalc_state_s st_r;
	daalc_pkg::daalc_state_s st_nxt;

	logic [7:0] loop_val;
	logic [7:0] volt_val;
	logic       pol_flip;
	logic       volt_zero;
	logic       loop_zero;
	logic       pol_flip_r;

	// current and voltage holders; readings stay signed bytes as sampled
	daalc_meas_hold u_loop (
		.clk       (CORE_CLK),
		.rst_n     (RSTN),
		.sample    (MEAS_STROBE),
		.value_in  (LOOP_CURRENT_IN),
		.value     (loop_val),
		.sign_flip (),
		.is_zero   (loop_zero)
	);
	daalc_meas_hold u_volt (
		.clk       (CORE_CLK),
		.rst_n     (RSTN),
		.sample    (MEAS_STROBE),
		.value_in  (LINE_VOLTAGE_IN),
		.value     (volt_val),
		.sign_flip (pol_flip),
		.is_zero   (volt_zero)
	);

	// write fires once address and data are both held
	logic        wr_fire;
	logic        ar_fire;
	logic        cal_start;
	logic        cal_done;
	logic [7:0]  rd_byte;
	logic [1:0]  rd_resp;
	logic [1:0]  wr_resp;
	logic [2:0]  evt_clr;

	assign wr_fire = st_r.aw_held && st_r.w_held && !st_r.bvalid;
	assign ar_fire = S_AXI_ARVALID && st_r.arready;

	// read decode, composed from live state
	always_comb
	begin
		rd_byte = 8'h00;
		rd_resp = `DAALC_RESP_OKAY;
		if (S_AXI_ARADDR == `DAALC_ADDR_TRIM)
			rd_byte = {st_r.cal == daalc_pkg::CAL_BUSY,
				st_r.manual, st_r.disable_auto, st_r.spare,
				st_r.trim};
		else if (S_AXI_ARADDR == `DAALC_ADDR_DC)
			rd_byte = st_r.dc;
		else if (S_AXI_ARADDR == `DAALC_ADDR_RSVD)
			rd_byte = 8'h00;
		else if (S_AXI_ARADDR == `DAALC_ADDR_LOOP)
			rd_byte = loop_val;
		else if (S_AXI_ARADDR == `DAALC_ADDR_VOLT)
			rd_byte = volt_val;
		else if (S_AXI_ARADDR == `DAALC_ADDR_EVT)
			rd_byte = {5'h00, st_r.evt};
		else
			rd_resp = `DAALC_RESP_SLVERR;
	end

	// write decode: only answer code and event clear mask here
	always_comb
	begin
		wr_resp = `DAALC_RESP_OKAY;
		evt_clr = 3'h0;
		// held address and data outlive the write, so gate on the fire
		if (wr_fire && st_r.aw_addr == `DAALC_ADDR_EVT && st_r.wstrb0)
			evt_clr = st_r.wdata[2:0];
		if (st_r.aw_addr != `DAALC_ADDR_TRIM &&
			st_r.aw_addr != `DAALC_ADDR_DC &&
			st_r.aw_addr != `DAALC_ADDR_RSVD &&
			st_r.aw_addr != `DAALC_ADDR_LOOP &&
			st_r.aw_addr != `DAALC_ADDR_VOLT &&
			st_r.aw_addr != `DAALC_ADDR_EVT)
			wr_resp = `DAALC_RESP_SLVERR;
	end

	// manual start on a rising write of the manual bit; auto after reset
	assign cal_start = (st_r.cal == daalc_pkg::CAL_IDLE) &&
		((wr_fire && st_r.wstrb0 && st_r.aw_addr == `DAALC_ADDR_TRIM &&
		st_r.wdata[`DAALC_BIT_MANUAL] && !st_r.manual) ||
		(st_r.first && !st_r.disable_auto));
	assign cal_done = (st_r.cal == daalc_pkg::CAL_BUSY) &&
		(st_r.cal_cnt == CAL_LAST);

	// next state of the whole bank
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.first = 1'b0;

		// bus channel capture; each channel is taken on its own
		if (S_AXI_AWVALID && st_r.awready)
		begin
			st_nxt.aw_held = 1'b1;
			st_nxt.aw_addr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && st_r.wready)
		begin
			st_nxt.w_held = 1'b1;
			st_nxt.wdata = S_AXI_WDATA;
			st_nxt.wstrb0 = S_AXI_WSTRB[0];
		end

		// register writes; bits above the low byte are ignored
		if (wr_fire)
		begin
			st_nxt.aw_held = 1'b0;
			st_nxt.w_held = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = wr_resp;
			if (st_r.wstrb0 && st_r.aw_addr == `DAALC_ADDR_TRIM)
			begin
				st_nxt.manual = st_r.wdata[6];
				st_nxt.disable_auto = st_r.wdata[5];
				st_nxt.spare = st_r.wdata[4];
				st_nxt.trim = st_r.wdata[3:0];
			end
			else if (st_r.wstrb0 && st_r.aw_addr == `DAALC_ADDR_DC)
				st_nxt.dc = st_r.wdata[7:0];
			// reserved and measurement slots take no write
		end
		if (st_r.bvalid && S_AXI_BREADY)
			st_nxt.bvalid = 1'b0;
		// ready only while the channel is free and no answer waits
		st_nxt.awready = !st_nxt.aw_held && !st_nxt.bvalid;
		st_nxt.wready = !st_nxt.w_held && !st_nxt.bvalid;

		// read path: one cycle from address to data
		if (ar_fire)
		begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rdata = {24'h0000_00, rd_byte};
			st_nxt.rresp = rd_resp;
		end
		else if (st_r.rvalid && S_AXI_RREADY)
			st_nxt.rvalid = 1'b0;
		st_nxt.arready = !st_nxt.rvalid;

		// calibration sequencer
		case (st_r.cal)
			daalc_pkg::CAL_IDLE:
			begin
				st_nxt.cal_cnt = 8'h00;
				if (cal_start)
					st_nxt.cal = daalc_pkg::CAL_BUSY;
			end
			daalc_pkg::CAL_BUSY:
			begin
				st_nxt.cal_cnt = st_r.cal_cnt + 8'h01;
				if (cal_done)
				begin
					// hardware result overrides a same-cycle trim write
					st_nxt.cal = daalc_pkg::CAL_IDLE;
					st_nxt.trim = CAL_TRIM_IN;
				end
			end
			default:
				st_nxt.cal = daalc_pkg::CAL_IDLE;
		endcase

		// sticky events: write one clears, a new event in the same
		// cycle keeps its bit set
		st_nxt.evt = (st_r.evt & ~evt_clr) |
			{loop_zero,
			volt_zero,
			pol_flip};
	end

	// state register
	always_ff @(posedge CORE_CLK)
	begin
		if (!RSTN)
		begin
			st_r <= '0;
			st_r.cal <= daalc_pkg::CAL_IDLE;
			st_r.first <= 1'b1;
			st_r.disable_auto <= 1'b0;
			st_r.dc <= `DAALC_RST_DC;
			st_r.evt <= `DAALC_RST_EVT;
			st_r.bresp <= `DAALC_RESP_OKAY;
			st_r.rresp <= `DAALC_RESP_OKAY;
			pol_flip_r <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			pol_flip_r <= pol_flip;
		end
	end

	// outputs straight from state flops
	assign S_AXI_AWREADY = st_r.awready;
	assign S_AXI_WREADY = st_r.wready;
	assign S_AXI_BVALID = st_r.bvalid;
	assign S_AXI_BRESP = st_r.bresp;
	assign S_AXI_ARREADY = st_r.arready;
	assign S_AXI_RVALID = st_r.rvalid;
	assign S_AXI_RDATA = st_r.rdata;
	assign S_AXI_RRESP = st_r.rresp;
	assign LINE_VOLTAGE_ADJUST = st_r.dc.v_adj;
	assign MIN_LOOP_CURRENT_SELECT = st_r.dc.min_i;
	assign CURRENT_CAP_ENABLE = st_r.dc.cap;
	assign DC_IMPEDANCE_SELECT = st_r.dc.imp;
	assign CALIBRATION_RUN = (st_r.cal == daalc_pkg::CAL_BUSY);
	assign TRIM_VALUE = st_r.trim;
	assign LOOP_CURRENT_VALUE = loop_val;
	assign LINE_VOLTAGE_VALUE = volt_val;
	assign POLARITY_REVERSED = pol_flip_r;

	// checks on the bank
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RSTN);

	a_busy_readback: assert property (
		(ar_fire && S_AXI_ARADDR == `DAALC_ADDR_TRIM) |=>
		S_AXI_RDATA[`DAALC_BIT_BUSY] ==
		$past(st_r.cal == daalc_pkg::CAL_BUSY))
		else $error("busy bit read back wrong");

	a_manual_start: assert property (
		(wr_fire && st_r.wstrb0 && st_r.aw_addr == `DAALC_ADDR_TRIM &&
		st_r.wdata[6] && !st_r.manual &&
		st_r.cal == daalc_pkg::CAL_IDLE) |=>
		CALIBRATION_RUN [*8])
		else $error("manual calibration did not start");

	a_cal_length: assert property (
		$rose(CALIBRATION_RUN) |->
		##199 CALIBRATION_RUN ##1 !CALIBRATION_RUN)
		else $error("calibration run length wrong");

	a_disable_reset: assert property (
		st_r.first |-> !st_r.disable_auto ##1 CALIBRATION_RUN)
		else $error("auto calibration not run after reset");

	a_dc_settings: assert property (
		(wr_fire && st_r.wstrb0 && st_r.aw_addr == `DAALC_ADDR_DC) |=>
		{LINE_VOLTAGE_ADJUST, MIN_LOOP_CURRENT_SELECT,
		CURRENT_CAP_ENABLE, DC_IMPEDANCE_SELECT} ==
		{$past(st_r.wdata[7:4]), $past(st_r.wdata[1:0])})
		else $error("dc settings not applied");

	a_ro_ignore: assert property (
		(wr_fire && !MEAS_STROBE && (st_r.aw_addr == `DAALC_ADDR_LOOP ||
		st_r.aw_addr == `DAALC_ADDR_VOLT)) |=>
		$stable(loop_val) && $stable(volt_val))
		else $error("measurement changed by a write");

	a_current_read: assert property (
		(ar_fire && S_AXI_ARADDR == `DAALC_ADDR_LOOP) |=>
		S_AXI_RVALID && S_AXI_RDATA == {24'h0000_00, $past(loop_val)})
		else $error("loop current read wrong");

	a_polarity_evt: assert property (
		pol_flip |=> st_r.evt[`DAALC_BIT_POLEVT] && POLARITY_REVERSED)
		else $error("polarity reversal not flagged");

	a_no_line: assert property (
		volt_zero |=> st_r.evt[`DAALC_BIT_NOLINE])
		else $error("no-line event not flagged");

	a_write_answer: assert property (
		wr_fire |=> S_AXI_BVALID && !S_AXI_AWREADY && !S_AXI_WREADY)
		else $error("write answer missing");

	c_manual_cal: cover property ($rose(CALIBRATION_RUN) && !st_r.first);
	c_polarity: cover property (pol_flip);
	c_volt_read: cover property (ar_fire &&
		S_AXI_ARADDR == `DAALC_ADDR_VOLT);
	c_bad_addr: cover property (S_AXI_BVALID &&
		S_AXI_BRESP == `DAALC_RESP_SLVERR);
endmodule
`default_nettype wire

/* File: daalc_tb.sv */
// Purpose: self-checking bench for the line control register bank
// Assumes: AXI4-Lite master tasks, one transfer at a time, bready/rready
//          raised with each request and dropped once the answer is seen
// Notes:   the bench plays the line side: trim result and measurements
`default_nettype none
`include "daalc_map.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int TIMEOUT_CYC = 5000;

	// clock, reset and bus
	logic        clk;
	logic        rstn;
	logic [11:0] awaddr;
	logic [11:0] araddr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [1:0]  bresp;
	logic [1:0]  rresp;
	logic        awvalid;
	logic        wvalid;
	logic        bready;
	logic        arvalid;
	logic        rready;
	logic        awready;
	logic        wready;
	logic        bvalid;
	logic        arready;
	logic        rvalid;
	// line side
	logic [1:0]  v_adj;
	logic [1:0]  min_i;
	logic        cap;
	logic        imp;
	logic        cal_run;
	logic [3:0]  trim_out;
	logic [3:0]  cal_trim;
	logic        strobe;
	logic [7:0]  loop_in;
	logic [7:0]  volt_in;
	logic [7:0]  loop_val;
	logic [7:0]  volt_val;
	logic        pol_rev;
	// bench counters
	int          err_total = 0;
	int          checked = 0;
	int          cycles = 0;
	int          pol_cnt = 0;
	int          run_cnt = 0;
	int          last_run = 0;

	daalc_regs dut (
		.CORE_CLK                (clk),
		.RSTN                    (rstn),
		.S_AXI_AWADDR            (awaddr),
		.S_AXI_AWVALID           (awvalid),
		.S_AXI_AWREADY           (awready),
		.S_AXI_WDATA             (wdata),
		.S_AXI_WSTRB             (4'hf),
		.S_AXI_WVALID            (wvalid),
		.S_AXI_WREADY            (wready),
		.S_AXI_BRESP             (bresp),
		.S_AXI_BVALID            (bvalid),
		.S_AXI_BREADY            (bready),
		.S_AXI_ARADDR            (araddr),
		.S_AXI_ARVALID           (arvalid),
		.S_AXI_ARREADY           (arready),
		.S_AXI_RDATA             (rdata),
		.S_AXI_RRESP             (rresp),
		.S_AXI_RVALID            (rvalid),
		.S_AXI_RREADY            (rready),
		.LINE_VOLTAGE_ADJUST     (v_adj),
		.MIN_LOOP_CURRENT_SELECT (min_i),
		.CURRENT_CAP_ENABLE      (cap),
		.DC_IMPEDANCE_SELECT     (imp),
		.CALIBRATION_RUN         (cal_run),
		.TRIM_VALUE              (trim_out),
		.CAL_TRIM_IN             (cal_trim),
		.MEAS_STROBE             (strobe),
		.LOOP_CURRENT_IN         (loop_in),
		.LINE_VOLTAGE_IN         (volt_in),
		.LOOP_CURRENT_VALUE      (loop_val),
		.LINE_VOLTAGE_VALUE      (volt_val),
		.POLARITY_REVERSED       (pol_rev)
	);

	// 100 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input string name, input logic [7:0] seen,
		input logic [7:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("wrong value %s: expected %h seen %h", name, exp, seen);
		end
	endtask

	// one register write; address and data offered together
	task automatic wr(input logic [11:0] a, input logic [7:0] d,
		input logic [1:0] er);
		@(posedge clk);
		awaddr  <= a;
		wdata   <= {24'h00_0000, d};
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		forever
		begin
			@(posedge clk);
			if (bvalid === 1'b1)
				break;
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
		end
		bready <= 1'b0;
		chk("write response", {6'h00, bresp}, {6'h00, er});
	endtask

	// one register read compared with the expected byte
	task automatic rc(input string name, input logic [11:0] a,
		input logic [7:0] e, input logic [1:0] er);
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		forever
		begin
			@(posedge clk);
			if (rvalid === 1'b1)
				break;
			if (arready === 1'b1)
				arvalid <= 1'b0;
		end
		rready <= 1'b0;
		chk("read response", {6'h00, rresp}, {6'h00, er});
		chk(name, rdata[7:0], e);
	endtask

	// one measurement sample; inputs change afterwards to prove the hold
	task automatic meas(input logic [7:0] l, input logic [7:0] v);
		@(posedge clk);
		strobe  <= 1'b1;
		loop_in <= l;
		volt_in <= v;
		@(posedge clk);
		strobe  <= 1'b0;
		loop_in <= ~l;
		volt_in <= ~v;
		repeat (4) @(posedge clk);
	endtask

	// watchdog, reversal pulse count and length of the last calibration
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (pol_rev === 1'b1)
			pol_cnt <= pol_cnt + 1;
		if (cal_run === 1'b1)
			run_cnt <= run_cnt + 1;
		else if (run_cnt != 0)
		begin
			last_run <= run_cnt;
			run_cnt  <= 0;
		end
		if (cycles == TIMEOUT_CYC)
		begin
			err_total = err_total + 1;
			end_of_test();
		end
	end

	initial
	begin
		rstn = 1'b0;
		{awaddr, araddr, wdata} = '0;
		{awvalid, wvalid, bready, arvalid, rready, strobe} = '0;
		loop_in  = 8'h00;
		volt_in  = 8'h00;
		cal_trim = 4'ha;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		// reset values while the automatic calibration runs
		rc("calibration busy", `DAALC_ADDR_TRIM, 8'h80, 2'b00);
		rc("dc reset", `DAALC_ADDR_DC, 8'h00, 2'b00);
		rc("loop reset", `DAALC_ADDR_LOOP, 8'h00, 2'b00);
		rc("volt reset", `DAALC_ADDR_VOLT, 8'h00, 2'b00);
		while (cal_run !== 1'b0)
			@(posedge clk);
		rc("calibration done", `DAALC_ADDR_TRIM, 8'h0a, 2'b00);
		chk("trim out", {4'h0, trim_out}, 8'h0a);
		$display("test reset and auto calibration done");
		// every setpoint and minimum current code; bits 3:2 stay zero
		for (int i = 0; i < 4; i++)
		begin
			logic [1:0] k;
			logic [7:0] d;
			k = i[1:0];
			d = {k, k ^ 2'b01, 2'b00, k[0], k[1]};
			wr(`DAALC_ADDR_DC, d, 2'b00);
			chk("setpoint", {6'h00, v_adj}, {6'h00, k});
			chk("min current", {6'h00, min_i}, {6'h00, k ^ 2'b01});
			chk("cap", {7'h00, cap}, {7'h00, k[0]});
			chk("impedance", {7'h00, imp}, {7'h00, k[1]});
			rc("dc readback", `DAALC_ADDR_DC, d, 2'b00);
		end
		wr(`DAALC_ADDR_DC, 8'hc2, 2'b00);
		rc("dc full scale", `DAALC_ADDR_DC, 8'hc2, 2'b00);
		$display("test dc termination done");
		// manual run with auto disabled and the spare bit set
		cal_trim <= 4'h5;
		wr(`DAALC_ADDR_TRIM, 8'h7a, 2'b00);
		while (cal_run !== 1'b1)
			@(posedge clk);
		rc("manual busy", `DAALC_ADDR_TRIM, 8'hfa, 2'b00);
		wr(`DAALC_ADDR_TRIM, 8'h3a, 2'b00);
		rc("manual cleared", `DAALC_ADDR_TRIM, 8'hba, 2'b00);
		while (cal_run !== 1'b0)
			@(posedge clk);
		rc("manual done", `DAALC_ADDR_TRIM, 8'h35, 2'b00);
		chk("manual trim", {4'h0, trim_out}, 8'h05);
		chk("run length", last_run[7:0], 8'hc8);
		chk("dc unchanged", {v_adj, min_i, 2'b00, cap, imp}, 8'hc2);
		$display("test manual calibration done");
		// measurements, sign flips and zero readings
		meas(8'h2d, 8'h0c);
		rc("loop value", `DAALC_ADDR_LOOP, 8'h2d, 2'b00);
		rc("volt value", `DAALC_ADDR_VOLT, 8'h0c, 2'b00);
		chk("no first flip", pol_cnt[7:0], 8'h00);
		meas(8'h2d, 8'h8c);
		chk("negative volt", volt_val, 8'h8c);
		chk("one flip", pol_cnt[7:0], 8'h01);
		rc("flip event", `DAALC_ADDR_EVT, 8'h01, 2'b00);
		meas(8'h00, 8'h00);
		chk("flip back", pol_cnt[7:0], 8'h02);
		chk("zero loop", loop_val, 8'h00);
		rc("zero events", `DAALC_ADDR_EVT, 8'h07, 2'b00);
		meas(8'h11, 8'h05);
		chk("same sign", pol_cnt[7:0], 8'h02);
		wr(`DAALC_ADDR_EVT, 8'h07, 2'b00);
		rc("events cleared", `DAALC_ADDR_EVT, 8'h00, 2'b00);
		meas(8'h11, 8'h85);
		rc("flip after clear", `DAALC_ADDR_EVT, 8'h01, 2'b00);
		$display("test measurements done");
		// writes to read-only places and an unmapped address
		wr(`DAALC_ADDR_LOOP, 8'hff, 2'b00);
		wr(`DAALC_ADDR_VOLT, 8'hff, 2'b00);
		rc("loop kept", `DAALC_ADDR_LOOP, 8'h11, 2'b00);
		rc("volt kept", `DAALC_ADDR_VOLT, 8'h85, 2'b00);
		rc("reserved reads", `DAALC_ADDR_RSVD, 8'h00, 2'b00);
		wr(12'h07c, 8'h55, 2'b10);
		rc("unmapped", 12'h07c, 8'h00, 2'b10);
		rc("dc kept", `DAALC_ADDR_DC, 8'hc2, 2'b00);
		$display("test access kinds done");
		end_of_test();
	end

endmodule
`default_nettype wire
